// >>> hw/dcte_channel.sv
// Purpose: one DMA transfer channel with APB registers
// Assumes: bus_rdata valid in the cycle bus_rd is high
// Notes:   two cycles per element, CPU halted through them
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module dcte_channel
    import dcte_pkg::*;
#(
    parameter int AW = 16,
    parameter int CW = 16
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Memory bus
    output logic                   bus_rd,
    output logic                   bus_wr,
    output logic      [AW-1:0]     bus_addr,
    output logic      [15:0]       bus_wdata,
    input  wire logic [15:0]       bus_rdata,
    // CPU control
    output logic                   cpu_halt,
    input  wire logic              cpu_rmw_busy,
    input  wire logic              nmi,
    // Trigger sources
    input  wire logic              external_trigger_input,
    input  wire logic              prev_chan_done_flag,
    input  wire logic [PER_N-1:0]  periph_flag,
    input  wire logic [PER_N-1:0]  periph_irq_en,
    input  wire logic              conv_set_by_hw,
    output logic      [PER_N-1:0]  periph_flag_clr,
    output logic                   channel_done_flag
);
    if (AW < 2 || AW > 32 || CW < 1 || CW > 32) begin : g_chk
        $error("dcte_channel: AW or CW out of range");
    end

    typedef struct packed {
        dcte_st_t         st;
        dcte_ctl_t        ctl;
        logic [AW-1:0]    sa, da, sa_w, da_w;
        logic [CW-1:0]    sz, sz_w;
        logic             loaded, trig_prev, brk;
        logic [1:0]       bcnt;
        logic [1:0]       ext_s;
        logic [PER_N-1:0] pf_s1, pf_s2;
        logic             rd, wr, halt;
        logic [AW-1:0]    addr;
        logic [15:0]      wdata;
        logic [PER_N-1:0] fclr;
        logic             rdy, err;
        logic [31:0]      rdata;
    } dcte_state_t;

    dcte_state_t s_r, s_nxt;

    function automatic logic [AW-1:0] step(input logic [AW-1:0] a,
                                           input logic [1:0] sel);
        case (sel)
            STEP_INC: step = a + AW'(1);
            STEP_DEC: step = a - AW'(1);
            default:  step = a;
        endcase
    endfunction

    // Control word laid out by the package field positions
    function automatic logic [31:0] ctl_word(input dcte_ctl_t c);
        ctl_word                 = 32'h0;
        ctl_word[CTL_MODE+:3]    = c.transfer_mode_select;
        ctl_word[CTL_DSTEP+:2]   = c.dest_step_select;
        ctl_word[CTL_SSTEP+:2]   = c.src_step_select;
        ctl_word[CTL_LEVEL]      = c.level_trigger_select;
        ctl_word[CTL_EN]         = c.channel_enable;
        ctl_word[CTL_DONE]       = c.channel_done_flag;
        ctl_word[CTL_SREQ]       = c.software_request;
        ctl_word[CTL_NMIEN]      = c.nmi_abort_enable;
        ctl_word[CTL_RMWG]       = c.rmw_finish_guard;
        ctl_word[CTL_TSEL+:4]    = c.trigger_source_select;
    endfunction

    function automatic logic [31:0] rdmux(input dcte_state_t s,
                                          input logic [11:0] a);
        rdmux = 32'h0;
        case (a)
            OFS_CTL: rdmux = ctl_word(s.ctl);
            OFS_SRC: rdmux = 32'(s.sa);
            OFS_DST: rdmux = 32'(s.da);
            OFS_CNT: rdmux = 32'(s.sz);
            default: rdmux = 32'h0;
        endcase
    endfunction

    logic             acc, wr_ctl, wr_dat, hit;
    logic             raw, trig, start, xfer_done, single, burst;
    logic             abort;
    logic [PER_N-1:0] per_ok;
    logic [3:0]       pidx;

    assign acc    = psel && penable && s_r.rdy;
    assign hit    = paddr inside {OFS_CTL, OFS_SRC, OFS_DST, OFS_CNT};
    assign wr_ctl = acc && pwrite && paddr == OFS_CTL;
    assign wr_dat = acc && pwrite && hit && paddr != OFS_CTL;
    assign single = s_r.ctl.transfer_mode_select[1:0] == 2'h0;
    assign burst  = s_r.ctl.transfer_mode_select[1];
    assign pidx   = s_r.ctl.trigger_source_select - TS_PER0;

    always_comb begin
        // masked by irq enable; conversion flag hardware-set only
        per_ok = s_r.pf_s2 & ~periph_irq_en;
        per_ok[PER_CONV] = per_ok[PER_CONV] & conv_set_by_hw;
        // trigger source select, reserved never fires
        case (s_r.ctl.trigger_source_select)
            TS_SOFT:  raw = s_r.ctl.software_request;
            TS_CHAIN: raw = prev_chan_done_flag;
            TS_EXT:   raw = s_r.ext_s[1];
            default:  raw = s_r.ctl.trigger_source_select >= TS_PER0 &&
                            s_r.ctl.trigger_source_select <= TS_PERN &&
                            per_ok[pidx[2:0]];
        endcase
    end

    assign trig = s_r.ctl.level_trigger_select ? raw
                                              : raw && !s_r.trig_prev;
    // zero count never starts; only idle accepts
    assign start = s_r.st == ST_IDLE && s_r.ctl.channel_enable &&
                   trig && s_r.sz != CW'(0);
    assign abort = nmi && s_r.ctl.nmi_abort_enable;
    assign xfer_done = s_r.st == ST_WR && s_r.sz == CW'(1);

    always_comb begin
        s_nxt = s_r;
        s_nxt.ext_s = {s_r.ext_s[0], external_trigger_input};
        s_nxt.pf_s1 = periph_flag;
        s_nxt.pf_s2 = s_r.pf_s1;
        s_nxt.trig_prev = raw;
        s_nxt.fclr = '0;
        // APB: one wait state, read data latched in it
        s_nxt.rdy = psel && penable && !s_r.rdy;
        s_nxt.err = psel && penable && !s_r.rdy && !hit;
        if (psel && penable && !s_r.rdy) begin
            s_nxt.rdata = rdmux(s_r, paddr);
        end
        if (wr_ctl) begin
            s_nxt.ctl.transfer_mode_select  = pwdata[CTL_MODE+:3];
            s_nxt.ctl.dest_step_select      = pwdata[CTL_DSTEP+:2];
            s_nxt.ctl.src_step_select       = pwdata[CTL_SSTEP+:2];
            s_nxt.ctl.level_trigger_select  = pwdata[CTL_LEVEL];
            s_nxt.ctl.channel_enable        = pwdata[CTL_EN];
            s_nxt.ctl.software_request      = pwdata[CTL_SREQ];
            s_nxt.ctl.nmi_abort_enable      = pwdata[CTL_NMIEN];
            s_nxt.ctl.rmw_finish_guard      = pwdata[CTL_RMWG];
            s_nxt.ctl.trigger_source_select = pwdata[CTL_TSEL+:4];
            s_nxt.ctl.channel_done_flag = s_r.ctl.channel_done_flag &&
                                          !pwdata[CTL_DONE];
        end
        if (wr_dat) begin
            case (paddr)
                OFS_SRC: s_nxt.sa = pwdata[AW-1:0];
                OFS_DST: s_nxt.da = pwdata[AW-1:0];
                default: s_nxt.sz = pwdata[CW-1:0];
            endcase
            // rewritten registers drop the frozen transfer
            s_nxt.loaded = 1'b0;
        end
        case (s_r.st)
            ST_IDLE: begin
                if (start) begin
                    if (!s_r.loaded) begin
                        s_nxt.sa_w = s_r.sa;
                        s_nxt.da_w = s_r.da;
                        s_nxt.sz_w = s_r.sz;
                        s_nxt.loaded = 1'b1;
                    end
                    s_nxt.bcnt = 2'h0;
                    if (s_r.ctl.trigger_source_select == TS_SOFT &&
                        !(wr_ctl && pwdata[CTL_SREQ])) begin
                        s_nxt.ctl.software_request = 1'b0;
                    end
                    if (s_r.ctl.trigger_source_select >= TS_PER0 &&
                        s_r.ctl.trigger_source_select <= TS_PERN) begin
                        s_nxt.fclr[pidx[2:0]] = 1'b1;
                    end
                    s_nxt.st = (s_r.ctl.rmw_finish_guard && cpu_rmw_busy)
                             ? ST_RMW : ST_RD;
                end
            end
            ST_RMW: begin
                if (!cpu_rmw_busy) begin
                    s_nxt.st = ST_RD;
                end
            end
            ST_RD: begin
                s_nxt.st = ST_WR;
            end
            ST_WR: begin
                s_nxt.sa_w = step(s_r.sa_w, s_r.ctl.src_step_select);
                s_nxt.da_w = step(s_r.da_w, s_r.ctl.dest_step_select);
                s_nxt.sz = s_r.sz - CW'(1);
                s_nxt.bcnt = s_r.bcnt + 2'h1;
                if (xfer_done) begin
                    // reload and flag; set beats software clear
                    s_nxt.sz = s_r.sz_w;
                    s_nxt.ctl.channel_done_flag = 1'b1;
                    s_nxt.loaded = 1'b0;
                    if (!s_r.ctl.transfer_mode_select[2]) begin
                        s_nxt.ctl.channel_enable = 1'b0;
                    end
                    s_nxt.st = ST_IDLE;
                    // repeated burst restarts on its own
                    if (burst && s_r.ctl.transfer_mode_select[2] &&
                        s_nxt.ctl.channel_enable && s_r.sz_w != CW'(0)) begin
                        s_nxt.sa_w = s_r.sa;
                        s_nxt.da_w = s_r.da;
                        s_nxt.loaded = 1'b1;
                        s_nxt.brk = 1'b0;
                        s_nxt.st = (s_r.bcnt == BURST_LAST) ? ST_BRK
                                                            : ST_RD;
                    end
                end else if (single) begin
                    s_nxt.st = ST_IDLE;
                end else if (burst && !s_nxt.ctl.channel_enable) begin
                    s_nxt.st = ST_IDLE;
                end else if (s_r.ctl.level_trigger_select && !raw) begin
                    s_nxt.st = ST_HOLD;
                end else if (burst && s_r.bcnt == BURST_LAST) begin
                    s_nxt.brk = 1'b0;
                    s_nxt.st = ST_BRK;
                end else begin
                    s_nxt.st = ST_RD;
                end
            end
            ST_HOLD: begin
                // resume where stopped, or drop on rewrite
                if (wr_dat) begin
                    s_nxt.st = ST_IDLE;
                end else if (raw) begin
                    s_nxt.st = ST_RD;
                end
            end
            ST_BRK: begin
                s_nxt.brk = 1'b1;
                if (s_r.brk == BRK_LAST) begin
                    s_nxt.st = ST_RD;
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase
        if (abort && s_r.st != ST_IDLE) begin
            s_nxt.st = ST_IDLE;
        end
        // CPU halted across both cycles of every element
        s_nxt.rd = s_nxt.st == ST_RD;
        s_nxt.wr = s_nxt.st == ST_WR;
        s_nxt.halt = s_nxt.rd || s_nxt.wr;
        s_nxt.addr = s_nxt.rd ? s_nxt.sa_w : s_nxt.da_w;
        if (s_r.st == ST_RD) begin
            s_nxt.wdata = bus_rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{st: ST_IDLE, ctl: CTL_RST, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata            = s_r.rdata;
    assign pready            = s_r.rdy;
    assign pslverr           = s_r.err;
    assign bus_rd            = s_r.rd;
    assign bus_wr            = s_r.wr;
    assign bus_addr          = s_r.addr;
    assign bus_wdata         = s_r.wdata;
    assign cpu_halt          = s_r.halt;
    assign periph_flag_clr   = s_r.fclr;
    assign channel_done_flag = s_r.ctl.channel_done_flag;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence q_released;
        !cpu_halt ##1 !cpu_halt;
    endsequence

    sequence q_element;
        bus_rd ##1 (bus_wr && cpu_halt);
    endsequence

    AST_ZERO_NOXFER: assert property (
        s_r.st == ST_IDLE && s_r.sz == CW'(0) |=> !bus_rd)
        else $error("transfer started with zero count");
    AST_TWO_CYCLE: assert property (
        s_r.st == ST_RD && !abort |-> q_element)
        else $error("element did not take two halted cycles");
    AST_SINGLE_ONE: assert property (
        bus_wr && single |=> !bus_rd && !bus_wr)
        else $error("single mode moved more than one element");
    AST_EN_CLEAR: assert property (
        xfer_done && !s_r.ctl.transfer_mode_select[2] && !wr_ctl
        |=> !s_r.ctl.channel_enable)
        else $error("enable not cleared at count zero");
    AST_REPEAT_EN: assert property (
        xfer_done && s_r.ctl.transfer_mode_select[2] &&
        s_r.ctl.channel_enable && !wr_ctl |=> s_r.ctl.channel_enable)
        else $error("repeated mode lost its enable");
    AST_DONE_SET: assert property (
        xfer_done |=> channel_done_flag && s_r.sz == $past(s_r.sz_w))
        else $error("count expiry did not reload and flag");
    AST_BURST_BREAK: assert property (
        s_r.st == ST_BRK && !s_r.brk |-> q_released)
        else $error("burst break not two free cycles");
    AST_DST_STEP: assert property (
        s_r.st == ST_WR && !xfer_done &&
        s_r.ctl.dest_step_select == STEP_INC
        |=> s_r.da_w == $past(s_r.da_w) + AW'(1))
        else $error("destination address not stepped");
    AST_NMI_STOP: assert property (
        abort && s_r.st != ST_IDLE |=> s_r.st == ST_IDLE ##1 !cpu_halt)
        else $error("NMI abort did not stop the channel");
    AST_SREQ_CLR: assert property (
        start && s_r.ctl.trigger_source_select == TS_SOFT && !wr_ctl
        |=> !s_r.ctl.software_request)
        else $error("software request not self-cleared");
endmodule

// >>> hw/dcte_pkg.sv
// Purpose: shared constants and types of the transfer channel
// Assumes: APB register bus, 32-bit data, one word per register
// Notes:   offsets are byte addresses
package dcte_pkg;
    localparam logic [11:0] OFS_CTL = 12'h000;
    localparam logic [11:0] OFS_SRC = 12'h004;
    localparam logic [11:0] OFS_DST = 12'h008;
    localparam logic [11:0] OFS_CNT = 12'h00C;
    // Control register field positions
    localparam int CTL_MODE  = 0;
    localparam int CTL_DSTEP = 3;
    localparam int CTL_SSTEP = 5;
    localparam int CTL_LEVEL = 7;
    localparam int CTL_EN    = 8;
    localparam int CTL_DONE  = 9;
    localparam int CTL_SREQ  = 10;
    localparam int CTL_NMIEN = 11;
    localparam int CTL_RMWG  = 12;
    localparam int CTL_TSEL  = 16;
    // Step select codes
    localparam logic [1:0] STEP_DEC = 2'h2;
    localparam logic [1:0] STEP_INC = 2'h3;
    // Trigger source codes; 11..15 reserved
    localparam logic [3:0] TS_SOFT  = 4'h0;
    localparam logic [3:0] TS_CHAIN = 4'h1;
    localparam logic [3:0] TS_EXT   = 4'h2;
    localparam logic [3:0] TS_PER0  = 4'h3;
    localparam logic [3:0] TS_PERN  = 4'hA;
    localparam int         PER_N    = 8;
    localparam int         PER_CONV = 7;
    // Element and burst pacing, reset transfer mode
    localparam logic [1:0] BURST_LAST = 2'h3;
    localparam logic       BRK_LAST   = 1'h1;
    localparam logic [2:0] MODE_RST   = 3'h0;

    typedef enum logic [2:0] {
        ST_IDLE, ST_RMW, ST_RD, ST_WR, ST_HOLD, ST_BRK
    } dcte_st_t;

    typedef struct packed {
        logic [2:0] transfer_mode_select;
        logic [1:0] dest_step_select;
        logic [1:0] src_step_select;
        logic       level_trigger_select;
        logic       channel_enable;
        logic       channel_done_flag;
        logic       software_request;
        logic       nmi_abort_enable;
        logic       rmw_finish_guard;
        logic [3:0] trigger_source_select;
    } dcte_ctl_t;

    localparam dcte_ctl_t CTL_RST = '{MODE_RST, 2'h0, 2'h0, 1'b0, 1'b0,
                                      1'b0, 1'b0, 1'b0, 1'b0, TS_SOFT};
endpackage

// >>> tb/dcte_mem_model.sv
// Purpose: memory and CPU side seen by the channel
// Assumes: read data needed only in the bus_rd cycle
// Notes:   counters restart on clr
`timescale 1ns/1ps
module dcte_mem_model (
    // Clock, reset, clear
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clr,
    // Channel bus
    input  wire logic        bus_rd,
    input  wire logic        bus_wr,
    input  wire logic        cpu_halt,
    input  wire logic [15:0] bus_addr,
    input  wire logic [15:0] bus_wdata,
    output logic      [15:0] bus_rdata,
    // Observed traffic
    output int               wr_cnt,
    output int               halt_cyc,
    output int               span,
    output logic      [15:0] waddr,
    output logic      [15:0] wdata
);
    logic [15:0] junk;
    int          cyc;
    int          first;
    // Junk outside read cycles, never a held value
    assign bus_rdata = bus_rd ? (bus_addr ^ 16'h5A00) : junk;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn || clr) begin
            wr_cnt   <= 0;
            halt_cyc <= 0;
            span     <= 0;
            first    <= 0;
        end else begin
            if (bus_wr) begin
                wr_cnt <= wr_cnt + 1;
                waddr  <= bus_addr;
                wdata  <= bus_wdata;
            end
            if (cpu_halt) begin
                halt_cyc <= halt_cyc + 1;
                if (halt_cyc == 0)
                    first <= cyc;
                span <= (halt_cyc == 0) ? 1 : cyc - first + 1;
            end
        end
    end
    always @(posedge pclk) begin
        junk <= ~junk ^ 16'h00FF;
        cyc  <= cyc + 1;
    end
    initial begin
        junk = 16'h0F0F;
        cyc  = 0;
    end
endmodule

// >>> tb/tb_dcte_channel.sv
// Purpose: self-checking bench of the transfer channel
// Assumes: APB with one wait state, triggers synchronised
// Notes:   nmi and conversion source driven by scenarios
`timescale 1ns/1ps
module tb_dcte_channel;
    import dcte_pkg::*;
    localparam logic [31:0] SRQ = 32'h1 << CTL_SREQ;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        bus_rd, bus_wr, cpu_halt, rmw, ext, prv, done, clr, cs;
    logic [15:0] bus_addr, bus_wdata, bus_rdata, waddr, wdata;
    logic [7:0]  pflag, pirq, pclr;
    logic        nmi, conv;
    int          fail_count, check_count, cyc, wr_cnt, halt_cyc, span;

    dcte_channel dcte_channel_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus_rd(bus_rd),
        .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .cpu_halt(cpu_halt), .cpu_rmw_busy(rmw),
        .nmi(nmi), .external_trigger_input(ext),
        .prev_chan_done_flag(prv), .periph_flag(pflag),
        .periph_irq_en(pirq), .conv_set_by_hw(conv),
        .periph_flag_clr(pclr), .channel_done_flag(done));
    dcte_mem_model dcte_mem_model_inst (
        .pclk(pclk), .presetn(presetn), .clr(clr), .bus_rd(bus_rd),
        .bus_wr(bus_wr), .cpu_halt(cpu_halt), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .wr_cnt(wr_cnt),
        .halt_cyc(halt_cyc), .span(span), .waddr(waddr), .wdata(wdata));

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Holds the request until pready, taken at that edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = pslverr ? 32'hEEEEEEEE : prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] ctl(input logic [2:0] m,
            input logic [1:0] ds, input logic [3:0] ts, input logic [31:0] x);
        return (32'(m) << CTL_MODE) | (32'(ds) << CTL_DSTEP) | x
             | (32'(STEP_INC) << CTL_SSTEP) | (32'h1 << CTL_EN)
             | (32'(ts) << CTL_TSEL);
    endfunction
    task automatic setup(input logic [31:0] sa, da, n);
        apb(1'b1, OFS_CTL, 32'h1 << CTL_DONE);
        apb(1'b1, OFS_SRC, sa);
        apb(1'b1, OFS_DST, da);
        apb(1'b1, OFS_CNT, n);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        while (done !== 1'b1 && n < 300) begin
            @(negedge pclk);
            n++;
        end
        repeat (3) @(negedge pclk);
        chk("done flag", {31'h0, done}, 32'h1);
        @(posedge pclk);
    endtask
    task automatic en_is(input logic e);
        apb(1'b0, OFS_CTL, 32'h0);
        chk("enable", {31'h0, q[CTL_EN]}, {31'h0, e});
    endtask

    task automatic t_regs;
        apb(1'b0, OFS_CTL, 32'h0);
        chk("ctl reset", q, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", q, 32'hEEEEEEEE);
        $display("test regs done");
    endtask
    task automatic t_block;
        setup(32'h0, 32'h0, 32'h0);
        apb(1'b1, OFS_CTL, ctl(3'h1, STEP_INC, TS_SOFT, SRQ));
        repeat (20) @(negedge pclk);
        chk("zero count writes", wr_cnt, 32'h0);
        setup(32'h0100, 32'h0200, 32'h3);
        apb(1'b1, OFS_CTL, ctl(3'h1, STEP_DEC, TS_SOFT, SRQ));
        wait_done();
        chk("block writes", wr_cnt, 32'h3);
        chk("last dest", waddr, 32'h01FE);
        chk("last data", wdata, 32'h5B02);
        chk("halt cycles", halt_cyc, 32'h6);
        chk("halt span", span, 32'h6);
        en_is(1'b0);
        chk("soft req", {31'h0, q[CTL_SREQ]}, 32'h0);
        apb(1'b0, OFS_CNT, 32'h0);
        chk("count reload", q, 32'h3);
        $display("test block done");
    endtask
    task automatic t_single;
        setup(32'h0300, 32'h0400, 32'h2);
        apb(1'b1, OFS_CTL, ctl(3'h0, STEP_INC, TS_SOFT, SRQ));
        repeat (20) @(negedge pclk);
        chk("single one", wr_cnt, 32'h1);
        en_is(1'b1);
        apb(1'b1, OFS_CTL, ctl(3'h0, STEP_INC, TS_SOFT, SRQ));
        wait_done();
        chk("single two", wr_cnt, 32'h2);
        chk("single dest", waddr, 32'h0401);
        en_is(1'b0);
        $display("test single done");
    endtask
    task automatic t_rep_ext;
        setup(32'h0500, 32'h0600, 32'h2);
        apb(1'b1, OFS_CTL, ctl(3'h5, STEP_INC, TS_EXT, 32'h0));
        repeat (2) begin
            ext <= 1'b1;
            repeat (12) @(posedge pclk);
            ext <= 1'b0;
            repeat (12) @(posedge pclk);
        end
        chk("edge blocks", wr_cnt, 32'h4);
        en_is(1'b1);
        $display("test repeated block done");
    endtask
    task automatic t_level;
        setup(32'h0B00, 32'h0C00, 32'h8);
        // level mode on the external input only
        apb(1'b1, OFS_CTL, ctl(3'h1, STEP_INC, TS_EXT,
                               32'h1 << CTL_LEVEL));
        ext <= 1'b1;
        while (wr_cnt < 2) @(negedge pclk);
        @(posedge pclk);
        ext <= 1'b0;
        repeat (20) @(negedge pclk);
        chk("level freeze", {31'h0, cpu_halt}, 32'h0);
        chk("level part", {31'h0, wr_cnt < 8}, 32'h1);
        @(posedge pclk);
        ext <= 1'b1;
        wait_done();
        chk("level resume", wr_cnt, 32'h8);
        chk("level dest", waddr, 32'h0C07);
        ext <= 1'b0;
        $display("test level done");
    endtask
    task automatic t_burst;
        int n;
        setup(32'h0700, 32'h0800, 32'h8);
        apb(1'b1, OFS_CTL, ctl(3'h2, STEP_INC, TS_SOFT, SRQ));
        wait_done();
        chk("burst writes", wr_cnt, 32'h8);
        chk("burst halt", halt_cyc, 32'h10);
        chk("burst span", span, 32'h12);
        en_is(1'b0);
        setup(32'h0900, 32'h0A00, 32'h4);
        apb(1'b1, OFS_CTL, ctl(3'h6, STEP_INC, TS_SOFT, SRQ));
        repeat (40) @(negedge pclk);
        chk("rep burst runs", {31'h0, wr_cnt > 8}, 32'h1);
        apb(1'b1, OFS_CTL, 32'h0);
        repeat (8) @(negedge pclk);
        setup(32'h0, 32'h0, 32'h1);
        repeat (20) @(negedge pclk);
        chk("rep burst stop", wr_cnt, 32'h0);
        setup(32'h0900, 32'h0A00, 32'h4);
        apb(1'b1, OFS_CTL, ctl(3'h6, STEP_INC, TS_SOFT,
                               SRQ | (32'h1 << CTL_NMIEN)));
        repeat (20) @(posedge pclk);
        nmi <= 1'b1;
        @(posedge pclk);
        nmi <= 1'b0;
        repeat (2) @(negedge pclk);
        n = wr_cnt;
        repeat (20) @(negedge pclk);
        chk("nmi ran", {31'h0, n > 0}, 32'h1);
        chk("nmi stop", wr_cnt, n);
        chk("nmi free", {31'h0, cpu_halt}, 32'h0);
        apb(1'b1, OFS_CTL, 32'h0);
        $display("test burst done");
    endtask
    task automatic t_trig;
        pirq <= 8'h01;
        apb(1'b1, OFS_CTL, ctl(3'h0, STEP_INC, TS_PER0, 32'h0));
        pflag <= 8'h01;
        repeat (12) @(negedge pclk);
        chk("masked flag", wr_cnt, 32'h0);
        @(posedge pclk);
        pflag <= 8'h00;
        repeat (4) @(posedge pclk);
        pirq  <= 8'h00;
        repeat (6) @(posedge pclk);
        cs = 1'b0;
        pflag <= 8'h01;
        wait_done();
        chk("flag writes", wr_cnt, 32'h1);
        chk("flag cleared", {31'h0, cs}, 32'h1);
        pflag <= 8'h00;
        setup(32'h0, 32'h0, 32'h1);
        apb(1'b1, OFS_CTL, ctl(3'h0, STEP_INC, TS_CHAIN, 32'h0));
        prv <= 1'b1;
        wait_done();
        chk("chain writes", wr_cnt, 32'h1);
        prv <= 1'b0;
        setup(32'h0, 32'h0, 32'h1);
        rmw <= 1'b1;
        apb(1'b1, OFS_CTL, ctl(3'h0, STEP_INC, TS_SOFT,
                               SRQ | (32'h1 << CTL_RMWG)));
        repeat (15) @(negedge pclk);
        chk("rmw wait", wr_cnt, 32'h0);
        @(posedge pclk);
        rmw <= 1'b0;
        wait_done();
        chk("rmw then go", wr_cnt, 32'h1);
        setup(32'h0, 32'h0, 32'h1);
        conv <= 1'b0;
        apb(1'b1, OFS_CTL, ctl(3'h0, STEP_INC, TS_PERN, 32'h0));
        pflag <= 8'h80;
        repeat (12) @(negedge pclk);
        chk("software conv flag", wr_cnt, 32'h0);
        @(posedge pclk);
        pflag <= 8'h00;
        repeat (4) @(posedge pclk);
        conv <= 1'b1;
        repeat (4) @(posedge pclk);
        pflag <= 8'h80;
        wait_done();
        chk("hw conv flag", wr_cnt, 32'h1);
        pflag <= 8'h00;
        $display("test triggers done");
    endtask

    always @(posedge pclk) begin
        if (pclr[0])
            cs = 1'b1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, rmw, ext, prv, clr, cs, nmi} = '0;
        conv = 1'b1;
        {paddr, pwdata, pflag, pirq} = '0;
        {fail_count, check_count, cyc} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_block();
        t_single();
        t_rep_ext();
        t_level();
        t_burst();
        setup(32'h0, 32'h0, 32'h1);
        t_trig();
        final_report();
    end
endmodule
